// [rtl/tmpc_codec.sv]
// Timing and management packet tail builder with running payload check.
// Assumes the upstream feeds header bytes, then emission times and
// transmitter entries on strobes; the tail is streamed out bytewise.
// Functional notes
// - Group number 0..127, one per packet.
// - Group number counts up, wraps after last.
// - Emission times must strictly increase.
// - Override code 000 normal, 111 override.
// - Filter count is codes minus one, nonzero.
// - Carrier offset -1..+1, -2 reserved.
// - Seconds word is low 32 TAI bits.
// - Nanoseconds word at most 999,999,999.
// - Transmitter loop holds count plus one.
// - Station address 13 bits, matches receiver.
// - Time offset signed 16-bit, 100 ns steps.
// - Filter index is assigned code minus one.
// - Release seconds are low 4 TAI bits.
// - Release subsecond is nanosecond bits 20..29.
// - Check covers length through last reserved bits.
// - Timestamp is 22 second bits plus ten.
// - Packetizer splits per scheduler settings.
// - UDP port identifies physical layer pipe.
// - Emission count minus one, entry 0 next.
`timescale 1ns/1ps
module tmpc_codec (
  // Clock and control
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Packet start and configuration
  input wire logic pkt_start_i,
  input wire tmpc_pkg::tmpc_cfg_t cfg_i,
  // Header bytes covered by the check (length onward)
  input wire logic hdr_valid_i,
  input wire logic [7:0] hdr_byte_i,
  // Emission time list
  input wire logic time_valid_i,
  input wire tmpc_pkg::tmpc_time_t time_i,
  // Per transmitter entries
  input wire logic xmtr_valid_i,
  input wire tmpc_pkg::tmpc_xmtr_t xmtr_i,
  // TAI clock at release, finish request and pipe number
  input wire logic [31:0] tai_sec_i,
  input wire logic [31:0] tai_ns_i,
  input wire logic finish_i,
  input wire logic [5:0] pipe_num_i,
  // Byte stream out
  output logic out_valid_o,
  output logic [7:0] out_byte_o,
  output logic out_last_o,
  input wire logic out_ready_i,
  // Status
  output logic [6:0] group_num_o,
  output logic [5:0] time_count_o,
  output logic [31:0] rtp_stamp_o,
  output logic [15:0] udp_port_o,
  output logic busy_o,
  output logic cfg_err_o,
  output logic order_err_o,
  output logic count_err_o
);
  import tmpc_pkg::*;

  typedef enum {ST_IDLE, ST_HDR, ST_EMIT, ST_CRC} tmpc_state_t;

  tmpc_state_t state_r;
  logic [6:0] group_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [63:0] shift_r;
  logic [3:0] left_r;
  logic [6:0] entries_r;
  logic [5:0] times_r;
  tmpc_time_t last_time_r;
  logic have_time_r;
  logic [7:0] in_byte;
  logic in_take;
  logic [15:0] rls_word;
  logic [7:0] cur_byte;

  assign cur_byte = shift_r[63:56];

  // Bytewise CCITT update over whatever byte enters the payload
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ TMPC_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Release word sampled in the finish_i cycle, when the tail is loaded
  assign rls_word = {tai_sec_i[3:0], tai_ns_i[31-2 -: 10], 2'h3};

  assign in_take = (state_r == ST_HDR) && hdr_valid_i;
  assign in_byte = (state_r == ST_EMIT) ? cur_byte : hdr_byte_i;
  assign crc_nxt = crc_step(crc_r, in_byte);

  // Handshake is combinational; the byte itself is a flip-flop
  assign out_valid_o = (state_r == ST_EMIT) || (state_r == ST_CRC);
  assign out_last_o = (state_r == ST_CRC) && (left_r == 4'h1);
  assign busy_o = (state_r != ST_IDLE);
  assign group_num_o = group_r;
  assign time_count_o = times_r;

  // Main sequencer
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      crc_r <= TMPC_CRC_INIT;
      shift_r <= '0;
      left_r <= '0;
      out_byte_o <= '0;
    end else if (clk_en_i) begin
      case (state_r)
        ST_IDLE: begin
          if (pkt_start_i) begin
            state_r <= ST_HDR;
            crc_r <= TMPC_CRC_INIT;
          end
        end
        ST_HDR: begin
          if (in_take) begin
            crc_r <= crc_nxt;
          end
          if (finish_i) begin
            // Tail: group, override, counts, offset, reserved, release
            shift_r <= {group_r, cfg_i.override_code, cfg_i.filt_count,
                        cfg_i.carrier_off, 6'h3f, rls_word,
                        28'h0};
            out_byte_o <= {group_r, cfg_i.override_code[2]};
            left_r <= 4'h5;
            state_r <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (out_ready_i) begin
            crc_r <= crc_nxt;
            shift_r <= {shift_r[55:0], 8'h0};
            out_byte_o <= shift_r[55:48];
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) begin
              state_r <= ST_CRC;
              out_byte_o <= crc_nxt[15:8];
              left_r <= 4'h2;
            end
          end
        end
        ST_CRC: begin
          if (out_ready_i) begin
            out_byte_o <= crc_r[7:0];
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Group numbering advances once per finished packet
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      group_r <= '0;
    end else if (clk_en_i && out_last_o && out_ready_i) begin
      if (group_r >= cfg_i.group_last || group_r == TMPC_GROUP_MAX) begin
        group_r <= '0;
      end else begin
        group_r <= group_r + 7'h1;
      end
    end
  end

  // Emission entry count; the first entry only arms the counter
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      times_r <= '0;
      have_time_r <= 1'b0;
    end else if (clk_en_i) begin
      if (pkt_start_i && state_r == ST_IDLE) begin
        times_r <= '0;
        have_time_r <= 1'b0;
      end else if (time_valid_i && state_r == ST_HDR) begin
        have_time_r <= 1'b1;
        if (have_time_r) begin
          times_r <= times_r + 6'h1;
        end
      end
    end
  end

  // Previous entry kept for the ordering compare
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      last_time_r <= '0;
    end else if (clk_en_i) begin
      if (time_valid_i && state_r == ST_HDR) begin
        last_time_r <= time_i;
      end
    end
  end

  // Ordering, range and list length errors, sticky per packet
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      order_err_o <= 1'b0;
    end else if (clk_en_i) begin
      if (pkt_start_i && state_r == ST_IDLE) begin
        order_err_o <= 1'b0;
      end else if (time_valid_i && state_r == ST_HDR) begin
        if (have_time_r && time_i <= last_time_r) begin
          order_err_o <= 1'b1;
        end
        if (time_i.nanoseconds > TMPC_NS_MAX ||
            (have_time_r && times_r == TMPC_NUM_MAX)) begin
          order_err_o <= 1'b1;
        end
      end
    end
  end

  // Entry 0 is the next frame and names its packets
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rtp_stamp_o <= '0;
    end else if (clk_en_i) begin
      if (time_valid_i && state_r == ST_HDR && !have_time_r &&
          !pkt_start_i) begin
        rtp_stamp_o <= {time_i.seconds[21:0],
                        time_i.nanoseconds[29:20]};
      end
    end
  end

  // Transmitter loop length
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      entries_r <= '0;
    end else if (clk_en_i) begin
      if (pkt_start_i && state_r == ST_IDLE) begin
        entries_r <= '0;
      end else if (xmtr_valid_i && state_r == ST_HDR) begin
        entries_r <= entries_r + 7'h1;
      end
    end
  end

  // An entry in the finishing cycle is not yet counted, so skip then
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      count_err_o <= 1'b0;
    end else if (clk_en_i) begin
      if (pkt_start_i && state_r == ST_IDLE) begin
        count_err_o <= 1'b0;
      end else if (finish_i && state_r == ST_HDR && !xmtr_valid_i) begin
        if (entries_r != {1'b0, cfg_i.group_size_m1} + 7'h1) begin
          count_err_o <= 1'b1;
        end
      end
    end
  end

  // Destination port follows the pipe number
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      udp_port_o <= TMPC_PORT_BASE;
    end else if (clk_en_i) begin
      if (pkt_start_i && state_r == ST_IDLE) begin
        udp_port_o <= TMPC_PORT_BASE + {10'h0, pipe_num_i};
      end
    end
  end

  // Configuration codes that must never be generated
  logic cfg_bad;
  assign cfg_bad = (cfg_i.filt_count == 2'h0) ||
                   (cfg_i.carrier_off == TMPC_CO_RESERVED) ||
                   (cfg_i.override_code != TMPC_OVR_NORMAL &&
                    cfg_i.override_code != TMPC_OVR_FORCE) ||
                   (tai_ns_i[29:20] > TMPC_MS_MAX);

  // Configuration and per-entry field checks, sticky per packet
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_err_o <= 1'b0;
    end else if (clk_en_i) begin
      if (pkt_start_i && state_r == ST_IDLE) begin
        cfg_err_o <= cfg_bad;
      end else if (xmtr_valid_i && state_r == ST_HDR) begin
        if (xmtr_i.filt_code > cfg_i.filt_count) begin
          cfg_err_o <= 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/tmpc_pkg.sv]
// Package for the timing and management packet tail codec.
// Assumes one clock domain; the builder streams bytes in network order.
package tmpc_pkg;
  localparam logic [6:0] TMPC_GROUP_MAX = 7'h7f;
  localparam logic [2:0] TMPC_OVR_NORMAL = 3'h0;
  localparam logic [2:0] TMPC_OVR_FORCE = 3'h7;
  localparam logic [1:0] TMPC_CO_RESERVED = 2'h2;
  localparam logic [31:0] TMPC_NS_MAX = 32'h3b9ac9ff;
  localparam logic [9:0] TMPC_MS_MAX = 10'h3b9;
  localparam logic [15:0] TMPC_CRC_INIT = 16'hffff;
  localparam logic [15:0] TMPC_CRC_POLY = 16'h1021;
  localparam logic [15:0] TMPC_PORT_BASE = 16'h7530;
  localparam logic [5:0] TMPC_NUM_MAX = 6'h3f;
  localparam int TMPC_ENTRY_BYTES = 8;
  localparam int TMPC_XMTR_BYTES = 8;
  localparam logic [6:0] TMPC_RSV6 = 7'h3f;

  typedef struct packed {
    logic [12:0] station_address;
    logic [15:0] time_offset;
    logic [3:0] inject_level;
    logic [1:0] filt_code;
  } tmpc_xmtr_t;

  typedef struct packed {
    logic [31:0] seconds;
    logic [31:0] nanoseconds;
  } tmpc_time_t;

  typedef struct packed {
    logic [5:0] group_size_m1;
    logic [6:0] group_last;
    logic [2:0] override_code;
    logic [1:0] filt_count;
    logic [1:0] carrier_off;
  } tmpc_cfg_t;
endpackage

// [sim/tmpc_codec_chk.sv]
// Port-level checker for the packet tail codec.
// Assumes clk_en_i is held high by the bench.
`timescale 1ns/1ps
module tmpc_codec_chk
  import tmpc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic pkt_start_i,
  input wire tmpc_pkg::tmpc_cfg_t cfg_i,
  input wire logic finish_i,
  input wire logic [5:0] pipe_num_i,
  input wire logic out_ready_i,
  input wire logic out_valid_o,
  input wire logic [7:0] out_byte_o,
  input wire logic out_last_o,
  input wire logic [6:0] group_num_o,
  input wire logic [15:0] udp_port_o,
  input wire logic busy_o,
  input wire logic cfg_err_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  wire logic fin_w = out_valid_o && out_ready_i && out_last_o;
  byte_hold_a: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(out_byte_o)) else $error("tail byte moved");
  tail_start_a: assert property (finish_i && busy_o && !out_valid_o
    |=> out_valid_o) else $error("tail did not start");
  port_map_a: assert property (pkt_start_i && !busy_o |=>
    udp_port_o == TMPC_PORT_BASE + {10'h0, $past(pipe_num_i)})
    else $error("port mismatch");
  group_step_a: assert property (fin_w |=> group_num_o ==
    ($past(group_num_o) == $past(cfg_i.group_last) ? 7'h0 :
    $past(group_num_o) + 7'h1)) else $error("group step wrong");
  cfg_flag_a: assert property (pkt_start_i && !busy_o |=>
    cfg_err_o == ($past(cfg_i.filt_count) == 2'h0 ||
    $past(cfg_i.carrier_off) == TMPC_CO_RESERVED)) else $error("cfg flag");
  last_valid_a: assert property (out_last_o |-> out_valid_o)
    else $error("last without valid");
  idle_quiet_a: assert property (!busy_o |-> !out_valid_o)
    else $error("output while idle");
  end_idle_a: assert property (fin_w |=> !out_valid_o)
    else $error("bytes after last");
  cover property (out_valid_o && !out_ready_i);
  cover property (fin_w && group_num_o == 7'h2);
  cover property (fin_w && cfg_err_o);
endmodule
bind tmpc_codec tmpc_codec_chk u_chk (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .pkt_start_i(pkt_start_i), .cfg_i(cfg_i),
  .finish_i(finish_i), .pipe_num_i(pipe_num_i), .out_ready_i(out_ready_i),
  .out_valid_o(out_valid_o), .out_byte_o(out_byte_o),
  .out_last_o(out_last_o), .group_num_o(group_num_o),
  .udp_port_o(udp_port_o), .busy_o(busy_o), .cfg_err_o(cfg_err_o));

// [sim/tmpc_sink.sv]
// Receiving station model: paces the tail stream and rechecks the word.
// Assumes it sees the same header bytes that the codec folds in.
`timescale 1ns/1ps
module tmpc_sink
  import tmpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Observed payload
  input wire logic hdr_valid_i,
  input wire logic [7:0] hdr_byte_i,
  input wire logic out_valid_i,
  input wire logic [7:0] out_byte_i,
  input wire logic out_last_i,
  // Pacing and verdict
  output logic out_ready_o,
  output logic chk_ok_o
);
  logic [15:0] crc_r, prev_r;
  logic [7:0] last_r;
  logic [1:0] pace_r;
  function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? TMPC_CRC_POLY : 16'h0);
    end
    return c;
  endfunction
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      crc_r <= TMPC_CRC_INIT;
      pace_r <= 2'h0;
      out_ready_o <= 1'b0;
    end else begin
      pace_r <= pace_r + 2'h1;
      // Stall one cycle in four so held bytes get exercised
      out_ready_o <= pace_r != 2'h0;
      if (hdr_valid_i) crc_r <= fold(crc_r, hdr_byte_i);
      if (out_valid_i && out_ready_o) begin
        last_r <= out_byte_i;
        prev_r <= crc_r;
        crc_r <= out_last_i ? TMPC_CRC_INIT : fold(crc_r, out_byte_i);
      end
    end
  end
  assign chk_ok_o = {last_r, out_byte_i} == prev_r;
endmodule

// [sim/tmpc_codec_test.sv]
// Self-checking bench for the packet tail codec.
// Assumes the sink model paces out_ready_i; clk_en_i is held high.
`timescale 1ns/1ps
module tmpc_codec_test;
  import tmpc_pkg::*;
  logic ref_clk_i = 0, sys_rst_i = 1, pkt_start_i = 0, hdr_valid_i = 0;
  logic time_valid_i = 0, xmtr_valid_i = 0, finish_i = 0, out_ready_i;
  logic out_valid_o, out_last_o, busy_o, cfg_err_o, order_err_o;
  logic count_err_o, chk_ok;
  logic [7:0] hdr_byte_i = 0, out_byte_o;
  tmpc_cfg_t cfg_i = '0;
  tmpc_time_t time_i = '0;
  tmpc_xmtr_t xmtr_i = '0;
  logic [31:0] tai_sec_i = 0, tai_ns_i = 0, rtp_stamp_o, rnd = 32'd85821;
  logic [5:0] pipe_num_i = 0, time_count_o;
  logic [6:0] group_num_o, grp = 0;
  logic [15:0] udp_port_o;
  logic [63:0] q[$];
  int n_errors = 0, comparisons = 0;
  tmpc_codec uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .pkt_start_i(pkt_start_i), .cfg_i(cfg_i),
    .hdr_valid_i(hdr_valid_i), .hdr_byte_i(hdr_byte_i),
    .time_valid_i(time_valid_i), .time_i(time_i),
    .xmtr_valid_i(xmtr_valid_i), .xmtr_i(xmtr_i), .tai_sec_i(tai_sec_i),
    .tai_ns_i(tai_ns_i), .finish_i(finish_i), .pipe_num_i(pipe_num_i),
    .out_valid_o(out_valid_o), .out_byte_o(out_byte_o),
    .out_last_o(out_last_o), .out_ready_i(out_ready_i),
    .group_num_o(group_num_o), .time_count_o(time_count_o),
    .rtp_stamp_o(rtp_stamp_o), .udp_port_o(udp_port_o), .busy_o(busy_o),
    .cfg_err_o(cfg_err_o), .order_err_o(order_err_o),
    .count_err_o(count_err_o));
  tmpc_sink far (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .hdr_valid_i(hdr_valid_i), .hdr_byte_i(hdr_byte_i),
    .out_valid_i(out_valid_o), .out_byte_i(out_byte_o),
    .out_last_i(out_last_o), .out_ready_o(out_ready_i), .chk_ok_o(chk_ok));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic err(input string m);
    n_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Codes: filter count, carrier offset, override; nt times, nx entries
  task automatic pkt(input logic [1:0] fc, co, input logic [2:0] ov,
      input int nt, nx, input bit bad);
    logic [31:0] s0, n0;
    @(posedge ref_clk_i);
    rnd = lfsr(rnd);
    cfg_i <= '{6'h1, 7'h2, ov, fc, co};
    pipe_num_i <= rnd[5:0];
    pkt_start_i <= 1'b1;
    q.push_back({grp, 32'h0, TMPC_PORT_BASE + {10'h0, rnd[5:0]}, 6'(nt - 1),
      fc == 2'h0 || co == 2'h2, bad, nx != 2});
    @(posedge ref_clk_i);
    pkt_start_i <= 1'b0;
    hdr_valid_i <= 1'b1;
    hdr_byte_i <= rnd[15:8];
    s0 = lfsr(rnd);
    n0 = {3'h0, rnd[28:0]};
    q[$][56:25] = {s0[21:0], n0[29:20]};
    grp = grp == 7'h2 ? 7'h0 : grp + 7'h1;
    for (int i = 0; i < nt; i++) begin
      @(posedge ref_clk_i);
      hdr_valid_i <= 1'b0;
      time_valid_i <= 1'b1;
      time_i <= '{s0 + 32'((bad && i == 1) ? 0 : i), n0};
    end
    for (int i = 0; i < nx; i++) begin
      @(posedge ref_clk_i);
      rnd = lfsr(rnd);
      time_valid_i <= 1'b0;
      xmtr_valid_i <= 1'b1;
      xmtr_i <= {rnd, rnd[2], rnd[1:0] & fc};
    end
    @(posedge ref_clk_i);
    xmtr_valid_i <= 1'b0;
    finish_i <= 1'b1;
    tai_sec_i <= rnd;
    tai_ns_i <= n0;
    @(posedge ref_clk_i);
    finish_i <= 1'b0;
    repeat (60) begin
      @(negedge ref_clk_i);
      if (busy_o === 1'b0) break;
    end
  endtask
  always @(posedge ref_clk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i && out_last_o === 1'b1) begin
      comparisons += 2;
      if (q.size() == 0) err("unexpected packet end");
      else if ({group_num_o, rtp_stamp_o, udp_port_o, time_count_o,
          cfg_err_o, order_err_o, count_err_o} !== q.pop_front())
        err("tail status mismatch");
      if (chk_ok !== 1'b1) err("check word mismatch");
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    pkt(2'h1, 2'h0, TMPC_OVR_NORMAL, 2, 2, 0);
    pkt(2'h2, 2'h1, TMPC_OVR_FORCE, 1, 2, 0);
    pkt(2'h3, 2'h3, TMPC_OVR_NORMAL, 3, 2, 1);
    pkt(2'h1, 2'h0, TMPC_OVR_NORMAL, 2, 3, 0);
    pkt(2'h0, 2'h0, TMPC_OVR_NORMAL, 2, 2, 0);
    pkt(2'h1, 2'h2, TMPC_OVR_NORMAL, 2, 2, 0);
    pkt(2'h1, 2'h0, TMPC_OVR_NORMAL, 64, 2, 0);
    repeat (5) @(posedge ref_clk_i);
    if (q.size() != 0) err("packets missing");
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_errors++;
    wrap_up();
  end
endmodule
